//--- src/reset_condition_effect_matrix.sv
// Reset and supply condition effect matrix with Wishbone control registers
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "reset_matrix_regs.svh"

// Contract
// - Power stages off on both PORs, main UV/OV and battery OV only.
// - Delayed outputs off on PORs and battery OV, delayed off on main UV/OV.
// - Transceivers off in internal POR, receive-only in ECU POR or main UV.
// - Transceivers off during main OV, restore configuration after release.
// - Tracker faults and battery OV keep configured transceiver behaviour.
// - After reset output rises, wait delay before applying stored transceiver setup.
// - Internal POR pulls both reset outputs low when supply allows.
// - Reset outputs low on ECU POR, main UV/OV; released otherwise.
// - Watchdog sequence and heartbeat reset on PORs, main UV/OV; restart after.
// - Watchdog, error, power-down, reset counters and safe timer cleared likewise.
// - Afterrun, wake enables, question, activation, configs, wd diagnosis cleared likewise; the CAN and LIN config bits are kept through main OV.
// - Logic bits reset on PORs and main UV; diagnosis set on UV and faults.
// - General reset applies to every bit not separately handled.
// - Active delayed switch-off preserves power-stage bits through reset.
// - ECU POR applies after ramp-up to normal, held for power-up time.
// - Supplies disabled during internal POR.
module reset_condition_effect_matrix
  import reset_matrix_pkg::*;
#(
  parameter int TPU_CYC  = `RM_TPU_CYC,
  parameter int TDEL_CYC = `RM_TDEL_CYC,
  parameter int DSO_CYC  = `RM_DSO_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Detected conditions
  input  wire logic        int_por_i,
  input  wire logic        pd_supply_ok_i,
  input  wire logic        ramp_done_i,
  input  wire logic        main_uv_i,
  input  wire logic        main_ov_i,
  input  wire logic        trk_uv_i,
  input  wire logic        trk_ov_i,
  input  wire logic        bat_ov_i,
  // Effects
  output logic             supplies_en_o,
  output logic             stages_en_o,
  output logic             delayed_out_en_o,
  output logic [1:0]       can_mode_o,
  output logic [1:0]       lin_mode_o,
  output logic             can_wake_en_o,
  output logic             lin_wake_en_o,
  output logic             monitor_reset_line_o,
  output logic             monitor_reset_line_oe_o,
  output logic             mcu_reset_o,
  output logic             mcu_reset_oe_o,
  output logic             wd_restart_o,
  output logic             wd_clear_o,
  output logic             logic_clear_o,
  output logic             irq_o
);

  localparam int CW = $clog2(TPU_CYC + TDEL_CYC + DSO_CYC + 1);
  localparam int NC = `RM_NCOND;

  logic [`RM_CTRL_W-1:0] ctrl_reg;
  logic [NC-1:0]         irq_stat_reg;
  logic [NC-1:0]         irq_en_reg;
  logic [NC-1:0]         diag_reg;
  logic [7:0]            gen_reg;
  logic [7:0]            pstage_reg;
  logic [NC-1:0]         cond;
  logic [NC-1:0]         cond_prev_reg;
  seq_state_t            seq_reg;
  logic [CW-1:0]         tpu_cnt_reg;
  logic [CW-1:0]         tdel_cnt_reg;
  logic [CW-1:0]         dso_cnt_reg;
  logic                  dso_active_reg;
  logic                  epor;
  logic                  rst_low;
  logic                  rst_low_prev_reg;
  logic                  hard_clear;
  logic                  xcvr_off;
  logic                  xcvr_rx;
  logic                  tdel_busy;
  xcvr_mode_t            xmode;
  logic                  wr;
  logic                  rd;
  logic                  hit;
  logic                  dso_start;
  logic [31:0]           dat_next;

  // ECU power-on reset: held for the power-up time after ramp-up completes
  always_ff @(posedge clk_i) begin
    if (rst_i || int_por_i) begin
      seq_reg     <= RAMP_UP;
      tpu_cnt_reg <= '0;
    end else begin
      case (seq_reg)
        RAMP_UP: if (ramp_done_i) begin
          seq_reg     <= EPOR_HOLD;
          tpu_cnt_reg <= CW'(TPU_CYC - 1);
        end
        EPOR_HOLD: if (tpu_cnt_reg == '0) begin
          seq_reg <= NORMAL;
        end else begin
          tpu_cnt_reg <= tpu_cnt_reg - 1'b1;
        end
        NORMAL: seq_reg <= NORMAL;
        default: seq_reg <= RAMP_UP;
      endcase
    end
  end

  // ECU reset begins on the edge that ramp-up completes, so the reset lines
  // see no one-cycle gap between internal and ECU power-on reset
  assign epor = (seq_reg == EPOR_HOLD) ||
                (seq_reg == RAMP_UP && ramp_done_i && !int_por_i);

  // Condition vector, bit order shared by status, interrupt and diagnosis words
  assign cond[0] = int_por_i;
  assign cond[1] = epor;
  assign cond[2] = main_uv_i;
  assign cond[3] = trk_uv_i;
  assign cond[4] = main_ov_i;
  assign cond[5] = trk_ov_i;
  assign cond[6] = bat_ov_i;

  // Conditions that pull the reset lines and clear watchdog state
  assign rst_low    = int_por_i | epor | main_uv_i | main_ov_i;
  assign hard_clear = rst_low;

  // Start seen combinationally so the delayed outputs never blink off in the
  // cycle in which main UV/OV first appears
  assign dso_start = (main_uv_i || main_ov_i) && !dso_active_reg &&
                     ctrl_reg[`RM_CTRL_DSO_BIT];

  // Delayed switch-off: started by main UV/OV, overridden by harder faults
  always_ff @(posedge clk_i) begin
    if (rst_i || int_por_i || epor || bat_ov_i) begin
      dso_active_reg <= 1'b0;
      dso_cnt_reg    <= '0;
    end else if (dso_start) begin
      dso_active_reg <= 1'b1;
      dso_cnt_reg    <= CW'(DSO_CYC - 1);
    end else if (dso_active_reg) begin
      if (dso_cnt_reg == '0) begin
        dso_active_reg <= 1'b0;
      end else begin
        dso_cnt_reg <= dso_cnt_reg - 1'b1;
      end
    end
  end

  // Delay after reset release before transceiver setup applies
  // Previous level starts high so a bench or power-up release also waits
  // Any new reset condition restarts the wait from zero
  always_ff @(posedge clk_i) begin
    rst_low_prev_reg <= rst_i ? 1'b1 : rst_low;
    if (rst_i) begin
      tdel_cnt_reg <= '0;
    end else if (rst_low) begin
      tdel_cnt_reg <= '0;
    end else if (rst_low_prev_reg) begin
      tdel_cnt_reg <= CW'(TDEL_CYC);
    end else if (tdel_cnt_reg != '0) begin
      tdel_cnt_reg <= tdel_cnt_reg - 1'b1;
    end
  end

  assign tdel_busy = rst_low_prev_reg || (tdel_cnt_reg != '0);

  // Transceiver requests from each condition
  assign xcvr_off = int_por_i | main_ov_i;
  assign xcvr_rx  = epor | main_uv_i | tdel_busy;

  // Most restrictive mode wins: off beats receive-only beats stored setup
  always_comb begin
    if (xcvr_off) begin
      xmode = XCVR_OFF;
    end else if (xcvr_rx) begin
      xmode = XCVR_RX_ONLY;
    end else begin
      xmode = XCVR_CFG;
    end
  end

  // Effect outputs, registered
  // One clock of latency, traded for glitch-free levels at the pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supplies_en_o    <= 1'b0;
      stages_en_o      <= 1'b0;
      delayed_out_en_o <= 1'b0;
      can_mode_o       <= 2'h2;
      lin_mode_o       <= 2'h2;
      wd_restart_o     <= 1'b0;
      wd_clear_o       <= 1'b1;
      logic_clear_o    <= 1'b1;
    end else begin
      supplies_en_o    <= !int_por_i;
      stages_en_o      <= !(rst_low || bat_ov_i);
      delayed_out_en_o <= !(int_por_i || epor || bat_ov_i) &&
                          (!(main_uv_i || main_ov_i) || dso_active_reg || dso_start);
      can_mode_o       <= (xmode == XCVR_CFG && !ctrl_reg[`RM_CTRL_CAN_BIT]) ? 2'h2 : 2'(xmode);
      lin_mode_o       <= (xmode == XCVR_CFG && !ctrl_reg[`RM_CTRL_LIN_BIT]) ? 2'h2 : 2'(xmode);
      wd_clear_o       <= hard_clear;
      wd_restart_o     <= rst_low_prev_reg && !rst_low;
      logic_clear_o    <= int_por_i || epor || main_uv_i;
    end
  end

  assign can_wake_en_o = ctrl_reg[`RM_CTRL_CAN_WAKE_ENABLE_BIT] && xmode == XCVR_CFG;
  assign lin_wake_en_o = ctrl_reg[`RM_CTRL_LIN_WAKE_ENABLE_BIT] && xmode == XCVR_CFG;

  // Open drain reset lines: drive low only, pull-up gives high
  // Data is tied low; only the enables move, so a line is never driven high
  // In internal POR below the pull-down supply limit the lines are left to the pull-up
  assign monitor_reset_line_o    = 1'b0;
  assign mcu_reset_o             = 1'b0;
  assign monitor_reset_line_oe_o = int_por_i ? pd_supply_ok_i : rst_low;
  assign mcu_reset_oe_o          = int_por_i ? pd_supply_ok_i : rst_low;

  // Bus decode: single cycle ack, error on unmapped word
  // Ack or err high blocks a second take while the master still holds stb
  assign hit = adr_i[1:0] == 2'h0 && adr_i <= `RM_GEN_ADDR;
  assign wr  = cyc_i && stb_i && we_i && !ack_o && !err_o && hit && sel_i[0];
  assign rd  = cyc_i && stb_i && !we_i && !ack_o && !err_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o && !err_o && hit;
      err_o <= cyc_i && stb_i && !ack_o && !err_o && !hit;
    end
  end

  // Control bits: wake enables, afterrun and activation cleared by hard faults;
  // CAN and LIN select bits survive main OV so the setup can return after it
  // The delayed-off enable is cleared too, so an expired switch-off cannot rearm
  always_ff @(posedge clk_i) begin
    if (rst_i || int_por_i || epor || main_uv_i) begin
      ctrl_reg <= `RM_CTRL_RESET;
    end else if (main_ov_i) begin
      ctrl_reg[`RM_CTRL_CAN_WAKE_ENABLE_BIT] <= 1'b0;
      ctrl_reg[`RM_CTRL_LIN_WAKE_ENABLE_BIT] <= 1'b0;
      ctrl_reg[`RM_CTRL_AR_BIT]    <= 1'b0;
      ctrl_reg[`RM_CTRL_ACT_BIT]   <= 1'b0;
      ctrl_reg[`RM_CTRL_DSO_BIT]   <= 1'b0;
    end else if (wr && adr_i == `RM_CTRL_ADDR) begin
      ctrl_reg <= dat_i[`RM_CTRL_W-1:0];
    end
  end

  // General logic bits, reset by PORs and main UV only
  always_ff @(posedge clk_i) begin
    if (rst_i || int_por_i || epor || main_uv_i) begin
      gen_reg <= 8'h00;
    end else if (wr && adr_i == `RM_GEN_ADDR) begin
      gen_reg <= dat_i[7:0];
    end
  end

  // Power-stage bits survive reset while delayed switch-off runs
  always_ff @(posedge clk_i) begin
    if (rst_i || ((int_por_i || epor || main_uv_i) && !(dso_active_reg || dso_start))) begin
      pstage_reg <= 8'h00;
    end else if (wr && adr_i == `RM_GEN_ADDR) begin
      pstage_reg <= dat_i[15:8];
    end
  end

  // Diagnosis bits: set by UV and fault conditions, set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i || int_por_i || epor) begin
      diag_reg <= '0;
    end else begin
      diag_reg <= (diag_reg & ~((wr && adr_i == `RM_DIAG_ADDR) ? dat_i[NC-1:0] : '0))
                  | {bat_ov_i, trk_ov_i, 1'b0, trk_uv_i, main_uv_i, 2'b00};
    end
  end

  // Interrupt status: sticky on condition rise, set wins over clear
  always_ff @(posedge clk_i) begin
    cond_prev_reg <= rst_i ? '0 : cond;
    if (rst_i) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((wr && adr_i == `RM_IRQ_CLR_ADDR) ? dat_i[NC-1:0] : '0))
                      | (cond & ~cond_prev_reg);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_reg <= '0;
    end else if (wr && adr_i == `RM_IRQ_EN_ADDR) begin
      irq_en_reg <= dat_i[NC-1:0];
    end
  end

  assign irq_o = |(irq_stat_reg & irq_en_reg);

  // Read data mux, clear-register and unmapped words read as zero
  always_comb begin
    case (adr_i)
      `RM_CTRL_ADDR:     dat_next = 32'(ctrl_reg);
      `RM_STAT_ADDR:     dat_next = {21'h0, dso_active_reg, tdel_busy, 2'(xmode), cond};
      `RM_IRQ_STAT_ADDR: dat_next = 32'(irq_stat_reg);
      `RM_IRQ_EN_ADDR:   dat_next = 32'(irq_en_reg);
      `RM_DIAG_ADDR:     dat_next = 32'(diag_reg);
      `RM_GEN_ADDR:      dat_next = {16'h0, pstage_reg, gen_reg};
      default:           dat_next = 32'h0000_0000;
    endcase
  end

  // Read data held until the next read, so a slow master still sees it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd) begin
      dat_o <= dat_next;
    end
  end

endmodule
`default_nettype wire

//--- src/reset_matrix_regs.svh
// Register offsets, field positions and timing counts of the reset condition matrix
`ifndef RESET_MATRIX_REGS_SVH
`define RESET_MATRIX_REGS_SVH

// Word byte addresses
`define RM_CTRL_ADDR      6'h00
`define RM_STAT_ADDR      6'h04
`define RM_IRQ_STAT_ADDR  6'h08
`define RM_IRQ_CLR_ADDR   6'h0C
`define RM_IRQ_EN_ADDR    6'h10
`define RM_DIAG_ADDR      6'h14
`define RM_GEN_ADDR       6'h18

// Control register fields
`define RM_CTRL_CAN_BIT   0
`define RM_CTRL_LIN_BIT   1
`define RM_CTRL_CAN_WAKE_ENABLE_BIT 2
`define RM_CTRL_LIN_WAKE_ENABLE_BIT 3
`define RM_CTRL_AR_BIT    4
`define RM_CTRL_ACT_BIT   5
`define RM_CTRL_DSO_BIT   6
`define RM_CTRL_W         7
`define RM_CTRL_RESET     7'h00

// Condition numbering, shared by status, interrupt and diagnosis layouts
`define RM_NCOND          7

// Timing in microseconds and derived cycles at 100 MHz
`define RM_CLK_MHZ        100
`define RM_TPU_US         1000
`define RM_TDEL_US        1000
`define RM_TPU_CYC        (`RM_TPU_US * `RM_CLK_MHZ)
`define RM_TDEL_CYC       (`RM_TDEL_US * `RM_CLK_MHZ)
`define RM_DSO_CYC        1000

`endif

//--- src/reset_matrix_pkg.sv
// Types for the reset condition matrix
package reset_matrix_pkg;
  // Transceiver mode, ordered least to most restrictive
  typedef enum logic [1:0] {
    XCVR_CFG,
    XCVR_RX_ONLY,
    XCVR_OFF
  } xcvr_mode_t;

  // Condition indices
  typedef enum logic [2:0] {
    C_IPOR, C_EPOR, C_UV5, C_UVT, C_OV5, C_OVT, C_OVB
  } cond_idx_t;

  typedef enum logic [1:0] {
    RAMP_UP,
    EPOR_HOLD,
    NORMAL
  } seq_state_t;
endpackage

//--- tb/reset_matrix_chk.sv
// Port-level checker for the reset condition effect matrix
`timescale 1ns/1ps
`default_nettype none
module reset_matrix_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       int_por_i,
  input wire logic       pd_supply_ok_i,
  input wire logic       main_uv_i,
  input wire logic       main_ov_i,
  input wire logic       bat_ov_i,
  input wire logic       supplies_en_o,
  input wire logic       stages_en_o,
  input wire logic       delayed_out_en_o,
  input wire logic [1:0] can_mode_o,
  input wire logic [1:0] lin_mode_o,
  input wire logic       monitor_reset_line_oe_o,
  input wire logic       mcu_reset_oe_o,
  input wire logic       wd_clear_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Hard conditions act one clock after they are seen
  a_stage_off: assert property ((int_por_i|main_uv_i|main_ov_i|bat_ov_i) |=> !stages_en_o)
    else $error("stages on in fault");
  a_delayed_off: assert property ((int_por_i | bat_ov_i) |=> !delayed_out_en_o)
    else $error("delayed output on");
  a_xcvr_off_por: assert property (int_por_i |=> can_mode_o == 2'h2 && lin_mode_o == 2'h2)
    else $error("transceiver on in POR");
  a_xcvr_off_ov: assert property (main_ov_i |=> can_mode_o == 2'h2 && lin_mode_o == 2'h2)
    else $error("transceiver on in OV");
  a_xcvr_rx_uv: assert property (main_uv_i |=> can_mode_o != 2'h0 && lin_mode_o != 2'h0)
    else $error("transceiver free in UV");
  // Two cycles of cause, though the enables are decoded from the inputs without a register
  a_pull_por: assert property ((int_por_i && pd_supply_ok_i)[*2]
    |-> monitor_reset_line_oe_o && mcu_reset_oe_o) else $error("lines free in POR");
  a_reset_low: assert property ((main_uv_i | main_ov_i)[*2]
    |-> monitor_reset_line_oe_o && mcu_reset_oe_o) else $error("lines free in UV/OV");
  a_supply_off: assert property (int_por_i |=> !supplies_en_o)
    else $error("supplies on in POR");
  a_wd_clear: assert property ((int_por_i | main_uv_i | main_ov_i) |=> wd_clear_o)
    else $error("watchdog not cleared");
endmodule
bind reset_condition_effect_matrix reset_matrix_chk i_chk (.clk_i, .rst_i, .int_por_i,
  .pd_supply_ok_i, .main_uv_i, .main_ov_i, .bat_ov_i, .supplies_en_o, .stages_en_o,
  .delayed_out_en_o, .can_mode_o, .lin_mode_o, .monitor_reset_line_oe_o, .mcu_reset_oe_o,
  .wd_clear_o);
`default_nettype wire

//--- tb/reset_line_partner.sv
// Microcontroller side of the two open-drain reset lines
`timescale 1ns/1ps
`default_nettype none
module reset_line_partner (
  input  wire logic mon_oe_i,
  input  wire logic mcu_oe_i,
  output logic      mon_lvl_o,
  output logic      mcu_lvl_o
);
  // Released lines float to the pull-up level
  assign mon_lvl_o = !mon_oe_i;
  assign mcu_lvl_o = !mcu_oe_i;
endmodule
`default_nettype wire

//--- tb/reset_condition_effect_matrix_tb.sv
// Self-checking bench for the reset condition effect matrix
`timescale 1ns/1ps
`default_nettype none
`include "reset_matrix_regs.svh"
module reset_condition_effect_matrix_tb;
  localparam int TDEL = 8;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, irq_o, e, mon_lvl, mcu_lvl;
  logic [5:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic        int_por_i, pd_supply_ok_i, ramp_done_i, main_uv_i, main_ov_i, trk_uv_i;
  logic        trk_ov_i, bat_ov_i, supplies_en_o, stages_en_o, delayed_out_en_o;
  logic [1:0]  can_mode_o, lin_mode_o;
  logic        can_wake_en_o, lin_wake_en_o, monitor_reset_line_oe_o, mcu_reset_oe_o;
  logic        wd_clear_o, logic_clear_o;
  int          failures, num_checks;

  reset_condition_effect_matrix #(.TPU_CYC(8), .TDEL_CYC(TDEL), .DSO_CYC(4)) i_dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o,
    .int_por_i, .pd_supply_ok_i, .ramp_done_i, .main_uv_i, .main_ov_i, .trk_uv_i, .trk_ov_i,
    .bat_ov_i, .supplies_en_o, .stages_en_o, .delayed_out_en_o, .can_mode_o, .lin_mode_o,
    .can_wake_en_o, .lin_wake_en_o, .monitor_reset_line_o(), .monitor_reset_line_oe_o,
    .mcu_reset_o(), .mcu_reset_oe_o, .wd_restart_o(), .wd_clear_o, .logic_clear_o, .irq_o);
  reset_line_partner i_mcu (.mon_oe_i(monitor_reset_line_oe_o), .mcu_oe_i(mcu_reset_oe_o),
    .mon_lvl_o(mon_lvl), .mcu_lvl_o(mcu_lvl));

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask

  // Effects packed as {sup,stg,dly,0, mon_oe,mcu_oe,mcu_lvl,mon_lvl, can,lin}
  task automatic eff(input logic [11:0] x);
    chk("effects", {20'h0, x}, {20'h0, supplies_en_o, stages_en_o, delayed_out_en_o, 1'b0,
      monitor_reset_line_oe_o, mcu_reset_oe_o, mcu_lvl, mon_lvl, can_mode_o, lin_mode_o});
  endtask

  // Classic single cycle, held until the slave answers; bounded so a dead slave shows
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic wait_rel;
    int n;
    n = 0;
    while (mcu_reset_oe_o !== 1'b0 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    chk("release", 32'h1, {31'h0, n < 60});
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Internal then ECU power-on reset, release delay, then configuration
  task automatic por_sc;
    tick(3);
    eff(12'h0CA);
    chk("clears", 32'h3, {30'h0, wd_clear_o, logic_clear_o});
    int_por_i <= 1'b0;
    ramp_done_i <= 1'b1;
    tick(3);
    eff(12'h8C5);
    wait_rel();
    tick(2);
    eff(12'hE35);
    tick(TDEL + 2);
    eff(12'hE3A);
    wb(1'b1, `RM_CTRL_ADDR, 32'h0F);
    tick(2);
    eff(12'hE30);
    chk("wake", 32'h3, {30'h0, can_wake_en_o, lin_wake_en_o});
  endtask

  // Tracker faults: no effect but diagnosis and a maskable interrupt
  task automatic trk_sc;
    wb(1'b1, `RM_IRQ_CLR_ADDR, 32'h7F);
    wb(1'b1, `RM_DIAG_ADDR, 32'h7F);
    wb(1'b1, `RM_IRQ_EN_ADDR, 32'h7F);
    trk_uv_i <= 1'b1;
    trk_ov_i <= 1'b1;
    tick(3);
    eff(12'hE30);
    chk("irq", 32'h1, {31'h0, irq_o});
    wb(1'b0, `RM_DIAG_ADDR, 32'h0);
    chk("diag", 32'h28, rd);
    trk_uv_i <= 1'b0;
    trk_ov_i <= 1'b0;
    wb(1'b1, `RM_IRQ_EN_ADDR, 32'h0);
    tick(1);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wb(1'b1, `RM_IRQ_CLR_ADDR, 32'h7F);
    wb(1'b0, `RM_IRQ_STAT_ADDR, 32'h0);
    chk("irq stat", 32'h0, rd);
    bat_ov_i <= 1'b1;
    tick(3);
    eff(12'h830);
    bat_ov_i <= 1'b0;
  endtask

  // Main overvoltage, then undervoltage with delayed switch-off, then a mix
  task automatic main_sc;
    main_ov_i <= 1'b1;
    tick(3);
    eff(12'h8CA);
    chk("clears", 32'h2, {30'h0, wd_clear_o, logic_clear_o});
    main_ov_i <= 1'b0;
    wait_rel();
    wb(1'b0, `RM_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h3, rd);
    wb(1'b1, `RM_CTRL_ADDR, 32'h43);
    tick(TDEL + 4);
    main_uv_i <= 1'b1;
    tick(2);
    eff(12'hAC5);
    tick(6);
    eff(12'h8C5);
    trk_ov_i <= 1'b1;
    bat_ov_i <= 1'b1;
    tick(3);
    eff(12'h8C5);
    {main_uv_i, trk_ov_i, bat_ov_i} <= 3'h0;
    wait_rel();
    wb(1'b0, 6'h1C, 32'h0);
    chk("err", 32'h1, {31'h0, e});
  endtask

  initial begin
    {cyc_i, stb_i, we_i, ramp_done_i, main_uv_i, main_ov_i, trk_uv_i, trk_ov_i} = 8'h00;
    {bat_ov_i, adr_i, dat_i} = '0;
    sel_i = 4'hF;
    {rst_i, int_por_i, pd_supply_ok_i} = 3'h7;
    failures = 0;
    num_checks = 0;
    tick(6);
    rst_i <= 1'b0;
    por_sc();
    trk_sc();
    main_sc();
    wrap_up();
  end

  // Watchdog against a hang
  initial begin
    tick(5000);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
